// ==== verilog/aeo_cfg.svh ====
// Constants of the angle encoder output stage: offsets, fields, timing.
// Assumes the including file runs its core logic at AEO_CLK_MHZ.
`ifndef AEO_CFG_SVH
`define AEO_CFG_SVH

// ==================================================================
// Clock and timing
`define AEO_CLK_MHZ          200
`define AEO_MONOFLOP_NS      19000
`define AEO_MONOFLOP_CYC     ((`AEO_MONOFLOP_NS * `AEO_CLK_MHZ) / 1000)
`define AEO_TACHO_BASE_NS    125000
`define AEO_TACHO_BASE_CYC   ((`AEO_TACHO_BASE_NS * `AEO_CLK_MHZ) / 1000)

// ==================================================================
// Register addresses
`define AEO_ADDR_REL_ANGLE   8'h20
`define AEO_ADDR_ABS_ANGLE   8'h21
`define AEO_ADDR_MAG_FLAGS   8'h22
`define AEO_ADDR_SPEED       8'h23

// ==================================================================
// Field positions
`define AEO_FLD_TOO_FAR      14
`define AEO_FLD_TOO_CLOSE    13
`define AEO_FLD_SPEED_OVF    10

// ==================================================================
// Widths and encodings
`define AEO_POS_W            12
`define AEO_SPEED_MAX        10'h3ff
`define AEO_SPEED_FULL       13'h0400
`define AEO_PHASE_V_OFS      12'h555
`define AEO_PHASE_W_OFS      12'haab
`define AEO_RING_ONCE_A      2'h0
`define AEO_RING_REPEAT      2'h1
`define AEO_RING_ONCE_B      2'h2
`define AEO_RING_FRESH       2'h3

`endif

// ==== verilog/aeo_pkg.sv ====
// Types of the angle encoder output stage.
// Assumes aeo_cfg.svh is on the include path.
`include "aeo_cfg.svh"

package aeo_pkg;

  // ================================================================
  // Configuration carried into the block
  typedef struct packed {
    logic [1:0] frame_repeat_sel;
    logic [2:0] res_sel;
    logic [2:0] speed_range_sel;
    logic       dac_enable;
    logic       sine_buffer_sel;
    logic [2:0] pole_pair_sel;
    logic [1:0] saw_period_sel;
    logic       dir_negative;
  } aeo_cfg_t;

  // ================================================================
  // Angle and magnet status from the interpolator
  typedef struct packed {
    logic [`AEO_POS_W-1:0] rel_pos;
    logic [`AEO_POS_W-1:0] abs_pos;
    logic                  too_far;
    logic                  too_close;
  } aeo_angle_t;

  // ================================================================
  // Commutation outputs
  typedef struct packed {
    logic u;
    logic v;
    logic w;
    logic oe;
  } aeo_phase_t;

  typedef enum logic {
    AEO_SSI_IDLE,
    AEO_SSI_BUSY
  } aeo_ssi_state_t;

endpackage

// ==== verilog/aeo_output_stage.sv ====
// Output stage of a magnetic angle encoder: serial word, register reads,
// speed, commutation and sawtooth codes. Assumes the serial clock comes
// from an outside controller and position inputs are on CLK.
//
// Overview of operation
// - Serial word plain binary, MSB first, max 12
// - Positive direction, clockwise turn: value increases
// - First falling edge latches position, starts monoflop
// - Every clock edge restarts monoflop, nominal 19us
// - MSB on first rising edge, then one per rise
// - After LSB, data line driven low
// - Pause beyond monoflop; expiry returns data high
// - Ring 00 or 10: word sent once only
// - Ring 01: same word repeated, zero between
// - Ring 11: fresh word each frame, zero between
// - Addresses 32, 33 give relative, absolute position
// - Address 34: too-far bit 14, too-close 13
// - Address 35: speed bits 9:0, overflow bit 10
// - Speed range code sets full scale, update time
// - DAC enable sends speed to the converter
// - Buffer select 0 drives digital U, V, W
// - Pole pairs code plus one; U starts at zero
// - Sawtooth code, 1/2/4/8 periods per revolution
// - Resolution code sets rate and word length
`timescale 1ns/10ps

module aeo_output_stage
  import aeo_pkg::*;
#(
  parameter int unsigned TACHO_BASE_CYC = `AEO_TACHO_BASE_CYC
) (
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  SSI_CLK,
  input  wire aeo_pkg::aeo_cfg_t     CFG,
  input  wire aeo_pkg::aeo_angle_t   ANGLE,
  input  wire logic [7:0]            REG_ADDR,
  output logic                       SSI_DATA,
  output logic [15:0]                REG_RD_DATA,
  output logic [9:0]                 DAC_CODE,
  output aeo_pkg::aeo_phase_t        PHASE
);
  import aeo_pkg::*;

  localparam logic [11:0] MF_CYC = 12'(`AEO_MONOFLOP_CYC);

  // ================================================================
  // Helpers
  function automatic logic [3:0] word_len(input logic [2:0] res);
    word_len = 4'(`AEO_POS_W) - {1'b0, res};
  endfunction

  function automatic logic [11:0] keep_upper(input logic [11:0] pos,
                                             input logic [2:0]  res);
    keep_upper = pos & (12'hfff << res);
  endfunction

  // ================================================================
  // Link domain: each serial clock edge flips a toggle
  // These keep running while CE is low so a single edge of each kind is not lost.
  logic link_fall_reg;
  logic link_rise_reg;

  always_ff @(negedge SSI_CLK or posedge RST) begin
    if (RST) begin
      link_fall_reg <= 1'b0;
    end else begin
      link_fall_reg <= ~link_fall_reg;
    end
  end

  always_ff @(posedge SSI_CLK or posedge RST) begin
    if (RST) begin
      link_rise_reg <= 1'b0;
    end else begin
      link_rise_reg <= ~link_rise_reg;
    end
  end

  // ================================================================
  // Core state
  typedef struct packed {
    logic [2:0]     fall_sync;
    logic [2:0]     rise_sync;
    aeo_ssi_state_t ssi_st;
    logic [11:0]    mf_cnt;
    logic [11:0]    shreg;
    logic [11:0]    word_hold;
    logic [3:0]     bits_left;
    logic           ssi_data;
    logic [31:0]    tacho_cnt;
    logic [11:0]    tacho_start;
    logic [9:0]     speed;
    logic           speed_ovf;
    logic [9:0]     dac_code;
    aeo_phase_t     phase;
    logic [15:0]    rd_data;
  } aeo_state_t;

  aeo_state_t state_reg;
  aeo_state_t state_next;

  logic [11:0] signed_pos;
  logic        fall_evt;
  logic        rise_evt;
  logic [11:0] cur_q;
  logic [11:0] diff;
  logic [12:0] mag;
  logic [31:0] tacho_last;
  logic [14:0] elec_full;
  logic [11:0] elec;
  logic [11:0] elec_v;
  logic [11:0] elec_w;
  logic [11:0] saw;

  always_comb begin
    state_next = state_reg;

    // Direction: negative counting mirrors the angle
    signed_pos = CFG.dir_negative ? 12'(12'h000 - ANGLE.rel_pos)
                                  : ANGLE.rel_pos;

    // ==============================================================
    // Edge events; only stages 2 and 3 are compared
    state_next.fall_sync = {state_reg.fall_sync[1:0], link_fall_reg};
    state_next.rise_sync = {state_reg.rise_sync[1:0], link_rise_reg};
    fall_evt = state_reg.fall_sync[2] ^ state_reg.fall_sync[1];
    rise_evt = state_reg.rise_sync[2] ^ state_reg.rise_sync[1];

    // ==============================================================
    // Serial shifter and monoflop
    case (state_reg.ssi_st)
      AEO_SSI_IDLE: begin
        state_next.ssi_data = 1'b1;
        if (fall_evt) begin
          state_next.shreg     = signed_pos;
          state_next.word_hold = signed_pos;
          state_next.bits_left = word_len(CFG.res_sel);
          state_next.mf_cnt    = MF_CYC;
          state_next.ssi_st    = AEO_SSI_BUSY;
        end
      end
      AEO_SSI_BUSY: begin
        if (fall_evt || rise_evt) begin
          state_next.mf_cnt = MF_CYC;
        end else if (state_reg.mf_cnt != 12'h000) begin
          state_next.mf_cnt = state_reg.mf_cnt - 12'h001;
        end else begin
          // Expired: line back high, next falling edge starts a read
          state_next.ssi_st   = AEO_SSI_IDLE;
          state_next.ssi_data = 1'b1;
        end
        if (rise_evt) begin
          if (state_reg.bits_left != 4'h0) begin
            state_next.ssi_data  = state_reg.shreg[11];
            state_next.shreg     = {state_reg.shreg[10:0], 1'b0};
            state_next.bits_left = state_reg.bits_left - 4'h1;
          end else begin
            state_next.ssi_data = 1'b0;
            case (CFG.frame_repeat_sel)
              `AEO_RING_REPEAT: begin
                state_next.shreg     = state_reg.word_hold;
                state_next.bits_left = word_len(CFG.res_sel);
              end
              `AEO_RING_FRESH: begin
                state_next.shreg     = signed_pos;
                state_next.word_hold = signed_pos;
                state_next.bits_left = word_len(CFG.res_sel);
              end
              default: begin
                state_next.bits_left = 4'h0;
              end
            endcase
          end
        end
      end
      default: begin
        state_next.ssi_st   = AEO_SSI_IDLE;
        state_next.ssi_data = 1'b1;
      end
    endcase

    // ==============================================================
    // Speed: position steps counted over one update window
    // Full scale lands at exactly 1024 steps for every range code.
    cur_q      = keep_upper(ANGLE.abs_pos, CFG.res_sel);
    diff       = 12'(cur_q - state_reg.tacho_start);
    mag        = diff[11] ? 13'({1'b0, 12'(12'h000 - diff)} >> CFG.res_sel)
                          : 13'({1'b0, diff} >> CFG.res_sel);
    tacho_last = 32'((TACHO_BASE_CYC << CFG.speed_range_sel) << CFG.res_sel)
                 - 32'h1;
    if (state_reg.tacho_cnt >= tacho_last) begin
      state_next.tacho_cnt   = 32'h0;
      state_next.tacho_start = cur_q;
      if (mag >= `AEO_SPEED_FULL) begin
        state_next.speed     = `AEO_SPEED_MAX;
        state_next.speed_ovf = 1'b1;
      end else begin
        state_next.speed     = mag[9:0];
        state_next.speed_ovf = 1'b0;
      end
    end else begin
      state_next.tacho_cnt = state_reg.tacho_cnt + 32'h1;
    end

    // ==============================================================
    // Converter code: speed or sawtooth
    saw = 12'(signed_pos << CFG.saw_period_sel);
    if (CFG.dac_enable) begin
      state_next.dac_code = state_reg.speed;
    end else begin
      state_next.dac_code = saw[11:2];
    end

    // ==============================================================
    // Commutation: electrical angle is position times pole pairs
    elec_full = 15'(signed_pos * ({1'b0, CFG.pole_pair_sel} + 4'h1));
    elec      = elec_full[11:0];
    state_next.phase.u  = ~elec[11];
    elec_v    = 12'(elec - `AEO_PHASE_V_OFS);
    elec_w    = 12'(elec - `AEO_PHASE_W_OFS);
    state_next.phase.v  = ~elec_v[11];
    state_next.phase.w  = ~elec_w[11];
    state_next.phase.oe = ~CFG.sine_buffer_sel;
    if (CFG.sine_buffer_sel) begin
      state_next.phase.u = 1'b0;
      state_next.phase.v = 1'b0;
      state_next.phase.w = 1'b0;
    end

    // ==============================================================
    // Register reads; unmapped addresses read zero
    case (REG_ADDR)
      `AEO_ADDR_REL_ANGLE: begin
        state_next.rd_data = {4'h0, signed_pos};
      end
      `AEO_ADDR_ABS_ANGLE: begin
        state_next.rd_data = {4'h0, ANGLE.abs_pos};
      end
      `AEO_ADDR_MAG_FLAGS: begin
        state_next.rd_data = 16'h0000;
        state_next.rd_data[`AEO_FLD_TOO_FAR]   = ANGLE.too_far;
        state_next.rd_data[`AEO_FLD_TOO_CLOSE] = ANGLE.too_close;
      end
      `AEO_ADDR_SPEED: begin
        state_next.rd_data = {5'h00, state_reg.speed_ovf, state_reg.speed};
      end
      default: begin
        state_next.rd_data = 16'h0000;
      end
    endcase
  end

  // ================================================================
  // Registers; CE low freezes the sync stages too, so a toggle
  // that arrives meanwhile is seen as one edge after release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg          <= '0;
      state_reg.ssi_st   <= AEO_SSI_IDLE;
      state_reg.ssi_data <= 1'b1;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  assign SSI_DATA    = state_reg.ssi_data;
  assign REG_RD_DATA = state_reg.rd_data;
  assign DAC_CODE    = state_reg.dac_code;
  assign PHASE       = state_reg.phase;

endmodule // aeo_output_stage

// ==== tb/aeo_output_stage_monitor.sv ====
// Port checker of the angle encoder output stage.
// Assumes it is bound into aeo_output_stage.
`timescale 1ns/10ps
module aeo_output_stage_monitor
  import aeo_pkg::*;
#(
  parameter int unsigned TACHO_BASE_CYC = 20
) (
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic               CE,
  input wire logic               SSI_CLK,
  input wire aeo_pkg::aeo_cfg_t   CFG,
  input wire aeo_pkg::aeo_angle_t ANGLE,
  input wire logic [7:0]         REG_ADDR,
  input wire logic               SSI_DATA,
  input wire logic [15:0]        REG_RD_DATA,
  input wire logic [9:0]         DAC_CODE,
  input wire aeo_pkg::aeo_phase_t PHASE
);
  // ==============================================================
  // Helpers
  logic [11:0] e_u;
  logic [11:0] e_v;
  logic [11:0] saw;
  logic [12:0] quiet_reg;
  logic [2:0]  rise_reg;
  logic        sclk_reg;
  assign e_u = ANGLE.rel_pos * ({1'b0, CFG.pole_pair_sel} + 4'h1);
  assign e_v = e_u - 12'h555;
  assign saw = ANGLE.rel_pos << CFG.saw_period_sel;
  // Counters saturate so a long idle never wraps into a false edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_reg  <= 1'b1;
      quiet_reg <= 13'h0;
      rise_reg  <= 3'h7;
    end else begin
      sclk_reg  <= SSI_CLK;
      quiet_reg <= (sclk_reg != SSI_CLK) ? 13'h0 : quiet_reg + {12'h0, quiet_reg != 13'h1fff};
      rise_reg  <= (!sclk_reg && SSI_CLK) ? 3'h0 : rise_reg + {2'h0, rise_reg != 3'h7};
    end
  end
  // ==============================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_abs_read: assert property (
    $past(CE && !RST) && $past(REG_ADDR) == 8'h21 |-> REG_RD_DATA == {4'h0, $past(ANGLE.abs_pos)})
    else $error("absolute read wrong");
  chk_unmapped_zero: assert property (
    $past(CE && !RST) && !($past(REG_ADDR) inside {[8'h20:8'h23]}) |-> REG_RD_DATA == 16'h0)
    else $error("unmapped read not zero");
  chk_magnet_flags: assert property (
    $past(CE && !RST) && $past(REG_ADDR) == 8'h22
    |-> REG_RD_DATA[14:13] == $past({ANGLE.too_far, ANGLE.too_close}))
    else $error("magnet flags wrong");
  chk_speed_field: assert property (
    $past(CE && !RST) && $past(REG_ADDR) == 8'h23
    |-> REG_RD_DATA[15:11] == 5'h0 && (!REG_RD_DATA[10] || REG_RD_DATA[9:0] == 10'h3ff))
    else $error("speed word malformed");
  chk_phase_off: assert property (
    $past(CE && !RST) && $past(CFG.sine_buffer_sel) |-> PHASE == 4'h0)
    else $error("phase driven while buffer selected");
  chk_phase_uv: assert property (
    $past(CE && !RST && !CFG.sine_buffer_sel && !CFG.dir_negative)
    |-> PHASE.oe && PHASE.u == !$past(e_u[11]) && PHASE.v == !$past(e_v[11]))
    else $error("commutation phase wrong");
  chk_saw_code: assert property (
    $past(CE && !RST && !CFG.dac_enable && !CFG.dir_negative) |-> DAC_CODE == $past(saw[11:2]))
    else $error("sawtooth code wrong");
  chk_idle_high: assert property (
    quiet_reg > 13'd3900 |-> SSI_DATA)
    else $error("data not high when idle");
  chk_bit_timing: assert property (
    $changed(SSI_DATA) |-> rise_reg < 3'h6 || quiet_reg > 13'd3790)
    else $error("data changed away from a rising clock");
  cover property ($past(REG_ADDR) == 8'h23 && REG_RD_DATA[10]);
  cover property ($rose(SSI_DATA));
  cover property (PHASE.oe && PHASE.u);
endmodule // aeo_output_stage_monitor

// ==== tb/aeo_ssi_ctrl.sv ====
// Position controller model: clocks the serial link, samples data.
// Assumes the device settles data well within one half period.
`timescale 1ns/10ps
module aeo_ssi_ctrl (
  output logic      SSI_CLK,
  input  wire logic SSI_DATA
);
  // Link period 240 ns; far under the 15 us monoflop minimum
  localparam int HALF_NS = 120;
  initial SSI_CLK = 1'b1; // Idles high
  task automatic read_bits(input int n, output logic [31:0] w);
    w = 32'h0;
    #3;
    for (int i = 0; i < n; i++) begin
      SSI_CLK = 1'b0; // Every frame starts from high
      #HALF_NS;
      SSI_CLK = 1'b1;
      #HALF_NS;
      w = {w[30:0], SSI_DATA};
    end
  endtask
  // Pause beyond the 25 us monoflop maximum
  task automatic rest();
    #26000;
  endtask
endmodule // aeo_ssi_ctrl

// ==== tb/aeo_output_stage_tb.sv ====
// Self-checking bench of the angle encoder output stage.
// Assumes the controller model drives the serial clock.
`timescale 1ns/10ps
module aeo_output_stage_tb;
  import aeo_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        sclk;
  logic        sdata;
  aeo_cfg_t    cfg;
  aeo_angle_t  angle;
  logic [7:0]  addr;
  logic [15:0] rd;
  logic [9:0]  dac;
  aeo_phase_t  phase;
  logic [31:0] w;
  logic [11:0] t;
  logic [10:0] tail;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  aeo_ssi_ctrl aeo_ssi_ctrl_i (.SSI_CLK(sclk), .SSI_DATA(sdata));
  // Short speed window keeps the run brief
  aeo_output_stage #(.TACHO_BASE_CYC(20)) aeo_output_stage_i (
    .CLK(clk), .RST(rst), .CE(ce), .SSI_CLK(sclk), .CFG(cfg), .ANGLE(angle),
    .REG_ADDR(addr), .SSI_DATA(sdata), .REG_RD_DATA(rd), .DAC_CODE(dac), .PHASE(phase));
  // ==============================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) addr <= a;
    @(posedge clk);
    #1;
    check("register", {16'h0, rd}, {16'h0, exp});
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ==============================================================
  // Sequence
  initial begin
    cfg = '0;
    angle = {12'h5a3, 12'h9c1, 2'b10};
    addr = 8'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    rdreg(8'h20, 16'h05a3);
    rdreg(8'h21, 16'h09c1);
    rdreg(8'h22, 16'h4000);
    rdreg(8'h23, 16'h0000);
    rdreg(8'h24, 16'h0000);
    @(posedge clk) cfg.dir_negative <= 1'b1;
    rdreg(8'h20, 16'h0a5d);
    @(posedge clk) cfg.dir_negative <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      fork
        repeat (200) @(posedge clk) angle.abs_pos <= angle.abs_pos + (k ? 12'd64 : 12'd1);
        begin
          repeat (150) @(posedge clk);
          rdreg(8'h23, k ? 16'h07ff : 16'h0014);
        end
      join
    end
    rdreg(8'h20, 16'h05a3);
    @(posedge clk) ce <= 1'b0;
    addr <= 8'h21;
    repeat (3) @(posedge clk);
    #1;
    check("frozen", {16'h0, rd}, 32'h05a3);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) cfg.res_sel <= 3'h2;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) cfg.frame_repeat_sel <= m[1:0];
      angle.rel_pos <= 12'h5a3;
      fork
        aeo_ssi_ctrl_i.read_bits(21, w);
        begin
          #1000;
          @(posedge clk) angle.rel_pos <= 12'h3c7;
        end
      join
      tail = (m == 1) ? {1'b0, 10'h168} : (m == 3) ? {1'b0, 10'h0f1} : 11'h0;
      check("frame", w, {11'h0, 10'h168, tail});
      aeo_ssi_ctrl_i.rest();
      check("idle", {31'h0, sdata}, 32'h1);
    end
    @(posedge clk) cfg.res_sel <= 3'h0; // Full rate for phases, DAC
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) cfg.pole_pair_sel <= k[2:0];
      cfg.saw_period_sel <= k[1:0];
      cfg.sine_buffer_sel <= (k == 7);
      cfg.dac_enable <= k[2];
      angle.rel_pos <= 12'h0;
      repeat (3) @(posedge clk);
      #1;
      check("phase", {28'h0, phase}, {28'h0, (k == 7) ? 4'h0 : 4'hb});
      @(posedge clk) angle.rel_pos <= 12'h5a3;
      repeat (3) @(posedge clk);
      #1;
      t = 12'h5a3 << k[1:0];
      check("dac", {22'h0, dac}, {22'h0, k[2] ? 10'h0 : t[11:2]});
    end
    tally_and_finish();
  end
endmodule // aeo_output_stage_tb

bind aeo_output_stage aeo_output_stage_monitor #(.TACHO_BASE_CYC(TACHO_BASE_CYC))
  aeo_output_stage_monitor_i (
  .CLK(CLK), .RST(RST), .CE(CE), .SSI_CLK(SSI_CLK), .CFG(CFG), .ANGLE(ANGLE),
  .REG_ADDR(REG_ADDR), .SSI_DATA(SSI_DATA), .REG_RD_DATA(REG_RD_DATA),
  .DAC_CODE(DAC_CODE), .PHASE(PHASE));
